// ==== hdl/wbl_pkg.sv ====
// Package for the ring tone warble divider: division ratios, warble ratios,
// Oscillator limits and the derived core clock counts.
// Assumes a 25 MHz core clock and an oscillator level sampled on that clock.
package wbl_pkg;

   // Core clock rate in hertz.
   localparam int unsigned WBL_CORE_CLK_HZ = 25_000_000;

   // Oscillator frequency limits in hertz (1.0 kHz to 10 kHz).
   localparam int unsigned WBL_OSC_MIN_HZ = 1_000;
   localparam int unsigned WBL_OSC_MAX_HZ = 10_000;

   // Longest oscillator period in core cycles, rounded up; beyond it the oscillator counts as stopped.
   localparam int unsigned WBL_OSC_STALL_CYC = (WBL_CORE_CLK_HZ + WBL_OSC_MIN_HZ - 1) / WBL_OSC_MIN_HZ;

   // Shortest oscillator period in core cycles, rounded down.
   localparam int unsigned WBL_OSC_MIN_CYC = WBL_CORE_CLK_HZ / WBL_OSC_MAX_HZ;

   // Tone division ratios and the count of high phases in each.
   localparam logic [2:0] WBL_DIV_HIGH_TONE = 3'h4;
   localparam logic [2:0] WBL_DIV_LOW_TONE = 3'h5;
   localparam logic [2:0] WBL_HIGH_LEN_4 = 3'h2;
   localparam logic [2:0] WBL_HIGH_LEN_5 = 3'h3;

   // Warble ratios of the three product variants.
   localparam logic [9:0] WBL_WARBLE_DIV_V1 = 10'h140;
   localparam logic [9:0] WBL_WARBLE_DIV_V2 = 10'h280;
   localparam logic [9:0] WBL_WARBLE_DIV_V3 = 10'h0A0;

   // Variant select codes.
   localparam logic [1:0] WBL_VARIANT_1 = 2'h0;
   localparam logic [1:0] WBL_VARIANT_2 = 2'h1;
   localparam logic [1:0] WBL_VARIANT_3 = 2'h2;

   // Oscillator ticks spent on each tone, half of one warble period.
   function automatic logic [8:0] wbl_half_ticks(input logic [1:0] variant);
      logic [9:0] full;
      full = WBL_WARBLE_DIV_V1;
      case (variant)
         WBL_VARIANT_2: full = WBL_WARBLE_DIV_V2;
         WBL_VARIANT_3: full = WBL_WARBLE_DIV_V3;
         default: full = WBL_WARBLE_DIV_V1;
      endcase
      return full[9:1];
   endfunction : wbl_half_ticks

endpackage : wbl_pkg

// ==== hdl/wbl_tone_if.sv ====
// Interface between the warble control and the tone divider.
// Assumes both ends share one clock and one active-low reset.
`timescale 1ns/1ps
interface wbl_tone_if (
   input wire logic clk,   // Core clock.
   input wire logic rst_n  // Asynchronous reset, active low.
);
   logic tick;      // One-cycle pulse per oscillator rising edge.
   logic enable;    // Tone divider runs while high.
   logic div5;      // High selects divide-by-5, low divide-by-4.
   logic tone;      // Divided square wave.
   logic cycle_end; // Pulse on the tick that ends a tone cycle.

   // Control end drives tick, enable and the ratio.
   modport ctl (input clk, input rst_n, output tick, output enable, output div5, input tone, input cycle_end);

   // Divider end answers with the tone and the cycle boundary.
   modport gen (input clk, input rst_n, input tick, input enable, input div5, output tone, output cycle_end);
endinterface : wbl_tone_if

// ==== hdl/wbl_tone_div.sv ====
// Tone divider: divides oscillator ticks by 4 or 5 into a square wave.
// Assumes the ratio changes only at a cycle boundary; it is latched there anyway.
`timescale 1ns/1ps
module wbl_tone_div
   import wbl_pkg::*;
(
   wbl_tone_if.gen tif  // Control link.
);

   typedef struct packed {
      logic [2:0] phase;
      logic cur_div5;
      logic tone;
   } wbl_div_state_t;

   wbl_div_state_t s;
   wbl_div_state_t next_s;
   logic [2:0] last;
   logic [2:0] high_len;

   // Last phase and high length of the ratio in use.
   assign last = s.cur_div5 ? WBL_DIV_LOW_TONE - 3'h1 : WBL_DIV_HIGH_TONE - 3'h1;
   assign high_len = s.cur_div5 ? WBL_HIGH_LEN_5 : WBL_HIGH_LEN_4;
   assign tif.cycle_end = tif.enable & tif.tick & (s.phase == last);
   assign tif.tone = s.tone;

   // Phase counter; while idle it rests on the last phase so the first tick opens a cycle.
   always_comb
   begin
      next_s = s;
      if (!tif.enable)
      begin
         next_s.cur_div5 = tif.div5;
         next_s.phase = tif.div5 ? WBL_DIV_LOW_TONE - 3'h1 : WBL_DIV_HIGH_TONE - 3'h1;
         next_s.tone = 1'b0;
      end
      else if (tif.tick)
      begin
         if (s.phase == last)
         begin
            next_s.phase = 3'h0;
            next_s.cur_div5 = tif.div5;
            next_s.tone = 1'b1;
         end
         else
         begin
            next_s.phase = s.phase + 3'h1;
            next_s.tone = (s.phase + 3'h1) < high_len;
         end
      end
   end

   // State register.
   always_ff @(posedge tif.clk or negedge tif.rst_n)
   begin
      if (!tif.rst_n)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   // Wrap happens exactly after 4 or 5 ticks.
   a_div_wrap: assert property (@(posedge tif.clk) disable iff (!tif.rst_n)
      tif.cycle_end |-> (s.phase == (s.cur_div5 ? 3'h4 : 3'h3)))
      else $error("tone divider wrapped at wrong phase");

   // Each non-final tick advances the phase by one.
   a_div_step: assert property (@(posedge tif.clk) disable iff (!tif.rst_n)
      (tif.enable && tif.tick && !tif.cycle_end) |=> (s.phase == $past(s.phase) + 3'h1))
      else $error("tone divider phase did not advance");

   // The square wave rises only at the start of a cycle.
   a_tone_rise: assert property (@(posedge tif.clk) disable iff (!tif.rst_n)
      $rose(s.tone) |-> $past(tif.cycle_end))
      else $error("tone rose away from cycle start");

endmodule : wbl_tone_div

// ==== hdl/wbl_ringer.sv ====
// Ring tone warble generator top: oscillator edge detection, warble timing,
// Ring gating and the registered tone output.
// Assumes the oscillator, ringing-detect and variant inputs are synchronous to CORE_CLK.
// Functional notes
// - The tone is the oscillator divided by 4 or by 5, the two ratios alternating.
// - The ratio swaps at a warble rate of the oscillator over 320, 640 or 160 by variant.
// - The tone output is driven only while ringing is detected, otherwise it stays low.
// - The tone output is a two-level square wave at the selected divided frequency.
`timescale 1ns/1ps
module wbl_ringer
   import wbl_pkg::*;
#(
   parameter int unsigned OSC_STALL_CYC = WBL_OSC_STALL_CYC  // Core cycles without an edge that mean a stopped oscillator.
)
(
   input wire logic CORE_CLK,          // Core clock, 25 MHz.
   input wire logic RSTN,              // Asynchronous reset, active low.
   input wire logic OSC_IN,            // Oscillator level from the timing pin.
   input wire logic RING_VALID,        // Ringing-detect comparator, high on valid ringing.
   input wire logic [1:0] VARIANT,     // Warble variant select.
   output logic TONE_OUTPUT_PIN,       // Tone to the output stage.
   output logic TONE_LOW_SEL,          // High while divide-by-5 is selected.
   output logic OSC_ALIVE              // High while oscillator edges keep arriving.
);

   typedef struct packed {
      logic osc_prev;
      logic [15:0] idle_cnt;
      logic [1:0] variant;
      logic [8:0] warble_cnt;
      logic swap_pend;
      logic low_sel;
      logic tone_out;
      logic alive;
   } wbl_top_state_t;

   wbl_top_state_t s;
   wbl_top_state_t next_s;
   logic tick;
   logic active;
   logic reach;
   logic swap;
   logic [8:0] half;
   logic [15:0] stall_lim;

   wbl_tone_if tif (
      .clk(CORE_CLK),
      .rst_n(RSTN)
   );

   wbl_tone_div u_div (
      .tif(tif)
   );

   // Oscillator edge, stall limit and ring gating.
   assign tick = OSC_IN & ~s.osc_prev;
   assign stall_lim = 16'(OSC_STALL_CYC);
   assign active = RING_VALID & s.alive;
   assign half = wbl_half_ticks(s.variant);
   assign reach = active & tick & (s.warble_cnt == half - 9'h001);
   assign swap = tif.cycle_end & (s.swap_pend | reach);

   // Link to the divider; the ratio handed over is the one for the next cycle.
   assign tif.tick = tick;
   assign tif.enable = active;
   assign tif.div5 = next_s.low_sel;

   // Outputs come straight from the state register.
   assign TONE_OUTPUT_PIN = s.tone_out;
   assign TONE_LOW_SEL = s.low_sel;
   assign OSC_ALIVE = s.alive;

   // Next state of the whole block.
   always_comb
   begin
      next_s = s;
      next_s.osc_prev = OSC_IN;
      // Time since the last oscillator edge, saturating at the stall limit.
      if (tick)
      begin
         next_s.idle_cnt = 16'h0000;
      end
      else if (s.idle_cnt < stall_lim)
      begin
         next_s.idle_cnt = s.idle_cnt + 16'h0001;
      end
      next_s.alive = next_s.idle_cnt < stall_lim;
      if (!active)
      begin
         // Idle: take a new variant, restart warble on the high tone.
         next_s.variant = VARIANT;
         next_s.warble_cnt = 9'h000;
         next_s.swap_pend = 1'b0;
         next_s.low_sel = 1'b0;
      end
      else
      begin
         if (tick)
         begin
            next_s.warble_cnt = reach ? 9'h000 : s.warble_cnt + 9'h001;
         end
         // A half period ending waits for the tone cycle to finish before swapping.
         next_s.swap_pend = (s.swap_pend | reach) & ~swap;
         next_s.low_sel = s.low_sel ^ swap;
      end
      next_s.tone_out = active & tif.tone;
   end

   // State register.
   always_ff @(posedge CORE_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         s <= '0;
      end
      else
      begin
         s <= next_s;
      end
   end

   // Without ringing the output is low the next cycle.
   a_ring_gate: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      !RING_VALID |=> !TONE_OUTPUT_PIN)
      else $error("tone driven without valid ringing");

   // Warble counter stays below half a warble period.
   a_warble_bound: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      s.warble_cnt < half)
      else $error("warble counter past half period");

   // Reaching half a period restarts the warble count.
   a_warble_wrap: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      reach |=> (s.warble_cnt == 9'h000) && (s.swap_pend || $changed(s.low_sel)))
      else $error("warble half period not taken");

   // A ratio swap while ringing only follows a tone cycle end.
   a_swap_aligned: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      ($changed(s.low_sel) && $past(active)) |-> $past(tif.cycle_end))
      else $error("tone ratio swapped mid cycle");

   // The output follows the divider tone by one cycle while ringing.
   a_tone_follow: assert property (@(posedge CORE_CLK) disable iff (!RSTN)
      active |=> (TONE_OUTPUT_PIN == $past(tif.tone)))
      else $error("tone output does not follow divider");

endmodule : wbl_ringer

// ==== tb/wbl_piezo_model.sv ====
// Piezo transducer stand-in that counts the level changes of its drive.
// Assumes the drive is a registered level sampled on the core clock.
`timescale 1ns/1ps
module wbl_piezo_model (
   input wire logic clk,        // Core clock.
   input wire logic rst_n,      // Reset, active low.
   input wire logic drive,      // Tone from the output stage.
   output int unsigned toggles  // Level changes seen so far.
);
   logic last;

   // Each change of the drive level flexes the element once.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         last <= 1'b0;
         toggles <= 0;
      end
      else
      begin
         last <= drive;
         if (drive !== last)
            toggles <= toggles + 1;
      end
   end
endmodule : wbl_piezo_model

// ==== tb/test_wbl_ringer.sv ====
// Self-checking bench for the ring tone warble generator top.
// Assumes an oscillator stand-in driven here and a shortened stall limit.
`timescale 1ns/1ps
module test_wbl_ringer;
   import wbl_pkg::*;
   typedef struct {logic [1:0] v; int h; int n;} wbl_row_t;
   logic CORE_CLK, RSTN, OSC_IN, RING_VALID;
   logic [1:0] VARIANT;
   logic TONE_OUTPUT_PIN, TONE_LOW_SEL, OSC_ALIVE;
   int fails, total_checks, osc_cnt, p;
   int unsigned toggles, seen;
   bit osc_run;
   logic exp_tone, exp_sel;
   // Variant, ticks per tone half, ticks to run before ringing stops.
   wbl_row_t rows[4] = '{'{2'h0, 160, 324}, '{2'h1, 320, 644}, '{2'h2, 80, 164}, '{2'h3, 160, 161}};

   wbl_ringer #(.OSC_STALL_CYC(200)) u_dut (.CORE_CLK(CORE_CLK), .RSTN(RSTN), .OSC_IN(OSC_IN),
      .RING_VALID(RING_VALID), .VARIANT(VARIANT), .TONE_OUTPUT_PIN(TONE_OUTPUT_PIN),
      .TONE_LOW_SEL(TONE_LOW_SEL), .OSC_ALIVE(OSC_ALIVE));
   wbl_piezo_model u_piezo (.clk(CORE_CLK), .rst_n(RSTN), .drive(TONE_OUTPUT_PIN), .toggles(toggles));

   // Core clock, 40 ns period.
   initial
   begin
      CORE_CLK = 1'b0;
      forever #20 CORE_CLK = ~CORE_CLK;
   end

   // Oscillator stand-in, 20 core cycles per period while enabled.
   always @(negedge CORE_CLK)
   begin
      if (osc_run)
      begin
         osc_cnt = (osc_cnt + 1) % 10;
         if (osc_cnt == 0)
            OSC_IN <= ~OSC_IN;
      end
   end

   // Compares one value and reports a mismatch at once.
   task automatic chk(input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value at %0t: expected %h got %h", $time, exp, got);
      end
   endtask : chk

   // Prints the counts and the verdict, then ends the run.
   task automatic final_report();
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : final_report

   // Cuts a hang short well beyond the expected run length.
   initial
   begin
      repeat (80000) @(posedge CORE_CLK);
      fails++;
      final_report();
   end

   // Reset, the table of ringing bursts, then the stalled oscillator.
   initial
   begin
      RSTN = 1'b0;
      OSC_IN = 1'b0;
      RING_VALID = 1'b0;
      VARIANT = 2'h0;
      osc_run = 1'b0;
      osc_cnt = 0;
      repeat (4) @(negedge CORE_CLK);
      chk(3'h0, {TONE_OUTPUT_PIN, TONE_LOW_SEL, OSC_ALIVE});
      repeat (4) @(negedge CORE_CLK);
      RSTN = 1'b1;
      repeat (30) @(negedge CORE_CLK);
      // The idle counter restarts from zero at reset, so the oscillator counts as alive until the stall limit.
      chk(1'h1, OSC_ALIVE);
      repeat (200) @(negedge CORE_CLK);
      chk(1'h0, OSC_ALIVE);
      osc_run = 1'b1;
      foreach (rows[i])
      begin
         VARIANT = rows[i].v;
         @(negedge OSC_IN);
         @(negedge CORE_CLK);
         RING_VALID = 1'b1;
         for (int t = 1; t <= rows[i].n; t++)
         begin
            @(posedge OSC_IN);
            repeat (5) @(negedge CORE_CLK);
            p = (t - 1) % (2 * rows[i].h);
            exp_tone = (p < rows[i].h) ? ((p % 4) < 2) : (((p - rows[i].h) % 5) < 3);
            // The swap waits for the tick that closes the last high-tone cycle, so it lands on tick h + 1.
            exp_sel = (p >= rows[i].h);
            chk(exp_tone, TONE_OUTPUT_PIN);
            chk(exp_sel, TONE_LOW_SEL);
         end
         RING_VALID = 1'b0;
         repeat (2) @(negedge CORE_CLK);
         chk(2'h0, {TONE_OUTPUT_PIN, TONE_LOW_SEL});
         seen = toggles;
         repeat (60) @(negedge CORE_CLK);
         chk(16'(seen), 16'(toggles));
      end
      RING_VALID = 1'b1;
      @(posedge OSC_IN);
      repeat (5) @(negedge CORE_CLK);
      osc_run = 1'b0;
      repeat (260) @(negedge CORE_CLK);
      chk(2'h0, {OSC_ALIVE, TONE_OUTPUT_PIN});
      osc_run = 1'b1;
      @(posedge OSC_IN);
      repeat (3) @(negedge CORE_CLK);
      chk(1'h1, OSC_ALIVE);
      final_report();
   end
endmodule : test_wbl_ringer
